/* File: ilad_cs_gen.sv */
// Purpose: condition status encoder from a result and carry
// Assumes: single results sit in bits 15:0
// Notes: purely combinational
`timescale 1ns/1ns
module ilad_cs_gen import ilad_pkg::*; (
  // result
  input wire logic [31:0] i_res,
  input wire logic i_dbl,
  // carry
  input wire logic i_carry,
  // status
  output logic [3:0] o_cs
);
  logic neg;
  logic zero;
  // sign and zero taken at the width of the operation
  always_comb begin
    neg = i_dbl ? i_res[31] : i_res[15];
    zero = i_dbl ? (i_res == 32'h0000_0000) : (i_res[15:0] == 16'h0000);
    o_cs = zero ? CS_ZERO : (neg ? CS_NEG : CS_POS);
    if (i_carry) begin
      o_cs = o_cs | CS_CARRY;
    end
  end
endmodule : ilad_cs_gen

/* File: ilad_mem_model.sv */
// Purpose: behavioural memory on the far side of the unit's bus
// Assumes: 256 words, picked by the low address byte
// Notes: i_wait sets the wait states before each ack; 0 acks in the request cycle
`timescale 1ns/1ns
module ilad_mem_model (
  // clock
  input wire logic i_clk,
  // request from the unit
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  // wait states chosen by the bench
  input wire logic [1:0] i_wait,
  // answer
  output logic o_ack,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [256];
  logic [1:0] wait_q = 2'h0;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] rd_addr_q = 16'h0000;
  logic rd_prev_q = 1'b0;
  logic pair_ok = 1'b0;
  int n_rd = 0;
  int n_wr = 0;
  // ack once the chosen wait states have run out
  assign o_ack = i_req && (wait_q == i_wait);
  // inverted junk outside a read ack, so a stale word can never pass for data
  assign o_rdata = (o_ack && !i_we) ? mem[i_addr[7:0]] : ~last_q;
  // transfer log, kept so the bench can see a read-modify-write pair
  always @(posedge i_clk) begin
    if (!i_req || o_ack) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
    if (o_ack && i_we) begin
      mem[i_addr[7:0]] <= i_wdata;
      n_wr <= n_wr + 1;
      pair_ok <= rd_prev_q && (rd_addr_q == i_addr);
    end
    if (o_ack && !i_we) begin
      n_rd <= n_rd + 1;
      rd_addr_q <= i_addr;
      last_q <= mem[i_addr[7:0]];
    end
    if (o_ack) begin
      rd_prev_q <= !i_we;
    end
  end
endmodule : ilad_mem_model

/* File: ilad_pkg.sv */
// Purpose: shared constants for the logic/magnitude/decrement execution unit
// Assumes: 16-bit words, register file of sixteen words
// Notes: cycle totals include fetch and operand bus cycles of the sequencer
package ilad_pkg;
  // opcode byte values
  localparam logic [7:0] OPC_MEM_DEC = 8'hB3;
  localparam logic [7:0] OPC_DBL_MAG = 8'hA5;
  localparam logic [7:0] OPC_SGL_MAG = 8'hA4;
  localparam logic [7:0] OPC_CONJ_MEM = 8'hE2;
  localparam logic [7:0] OPC_CONJ_RR = 8'hE3;
  localparam logic [7:0] OPC_IMM_GRP = 8'h4A;
  localparam logic [7:0] OPC_NCONJ_MEM = 8'hE6;
  localparam logic [7:0] OPC_NCONJ_RR = 8'hE7;
  // sub-opcodes of the immediate group and base forms
  localparam logic [3:0] SUB_CONJ_IMM = 4'h7;
  localparam logic [3:0] SUB_NCONJ_IMM = 4'hB;
  localparam logic [3:0] NIB_BASE_REL = 4'h3;
  localparam logic [3:0] NIB_BASE_IDX = 4'h4;
  localparam logic [1:0] SC_CONJ_BREL = 2'h1;
  localparam logic [1:0] SC_CONJ_BIDX = 2'h0;
  localparam logic [3:0] SUB_CONJ_BIDX = 4'hE;
  localparam logic [3:0] BASE_REG_OFS = 4'hC;
  // total clock cycles per form
  localparam logic [4:0] CYC_MEM_DEC = 5'd17;
  localparam logic [4:0] CYC_DBL_POS = 5'd13;
  localparam logic [4:0] CYC_DBL_NEG = 5'd21;
  localparam logic [4:0] CYC_SGL_POS = 5'd5;
  localparam logic [4:0] CYC_SGL_NEG = 5'd10;
  localparam logic [4:0] CYC_CONJ_MEM = 5'd12;
  localparam logic [4:0] CYC_CONJ_BASE = 5'd11;
  localparam logic [4:0] CYC_CONJ_IMM = 5'd11;
  localparam logic [4:0] CYC_CONJ_RR = 5'd4;
  localparam logic [4:0] CYC_NCONJ_MEM = 5'd15;
  localparam logic [4:0] CYC_NCONJ_IMM = 5'd14;
  localparam logic [4:0] CYC_NCONJ_RR = 5'd7;
  localparam logic [4:0] CYC_ILLEGAL = 5'd2;
  // pending interrupt bit for fixed point overflow
  localparam int PI_FIX_OVF_BIT = 4;
  // condition status codes
  localparam logic [3:0] CS_ZERO = 4'h2;
  localparam logic [3:0] CS_NEG = 4'h1;
  localparam logic [3:0] CS_POS = 4'h4;
  localparam logic [3:0] CS_CARRY = 4'h8;
  localparam logic [15:0] SGL_MIN = 16'h8000;
  localparam logic [31:0] DBL_MIN = 32'h8000_0000;
  // operation classes
  typedef enum logic [2:0] {
    ILAD_OP_DEC, ILAD_OP_DMAG, ILAD_OP_SMAG, ILAD_OP_CONJ, ILAD_OP_NCONJ, ILAD_OP_ILL
  } ilad_op_t;
endpackage : ilad_pkg

/* File: ilad_unit.sv */
// Purpose: execution unit for memory decrement, magnitude and conjunction forms
// Assumes: sequencer supplies instruction and second word with a start pulse
// Notes: memory handshake is on the same clock; ack may come in the request cycle
// Operation
// [RQ1] decrement subtracts count 1..16 from addressed word, writes it back
// [RQ2] decrement sets pending bit 4 when negative word turns positive
// [RQ3] decrement still stores the result on overflow
// [RQ4] decrement status from carry and sign, carry adds the top bit
// [RQ5] decrement opcode B3, count minus one, index field, address word
// [RQ6] decrement takes 17 cycles
// [RQ7] double magnitude negates negative 32-bit pair, upper half first
// [RQ8] double magnitude of 8000 0000 sets pending bit 4 and ends
// [RQ9] double magnitude status: minimum negative, zero or positive
// [RQ10] double magnitude opcode A5, 13 cycles positive, 21 negative
// [RQ11] single magnitude negates negative source, registers may coincide
// [RQ12] single magnitude of 8000 sets pending bit 4 and ends
// [RQ13] single magnitude status: minimum negative, zero or positive
// [RQ14] single magnitude opcode A4, 5 cycles positive, 10 negative
// [RQ15] conjunction ANDs operand into first register
// [RQ16] conjunction status zero, negative or positive
// [RQ17] direct/indexed conjunction opcode E2, address word, 12 cycles
// [RQ18] base relative conjunction, base minus 12, displacement, 11 cycles
// [RQ19] base indexed conjunction, sub-opcode E, index field, 11 cycles
// [RQ20] immediate conjunction 4A sub-opcode 7, data word, 11 cycles
// [RQ21] register conjunction opcode E3, 4 cycles
// [RQ22] inverted conjunction stores complement of the AND
// [RQ23] register inverted conjunction with equal fields gives NOT
// [RQ24] direct/indexed inverted conjunction opcode E6, 15 cycles
// [RQ25] decrement is read then write of same address, nothing between
`timescale 1ns/1ns
module ilad_unit import ilad_pkg::*; #(
  parameter int REGS = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // instruction issue
  input wire logic i_start,
  input wire logic [15:0] i_instr,
  input wire logic [15:0] i_ext,
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  // register load and read back
  input wire logic i_ld_en,
  input wire logic [3:0] i_ld_sel,
  input wire logic [15:0] i_ld_data,
  input wire logic [3:0] i_rd_sel,
  output logic [15:0] o_rd_data,
  // memory bus
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [15:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  // status
  output logic [3:0] o_cs,
  output logic [15:0] o_pending_interrupt_set
);
  typedef enum logic [2:0] {S_IDLE, S_RD, S_EXEC, S_WR, S_PAD, S_DONE} ilad_st_t;

  logic [15:0] rf_q [REGS];
  ilad_st_t st_q, st_d;
  ilad_op_t op_q, op_d;
  logic [3:0] ra_q, ra_d, rb_q, rb_d, cs_q, cs_d, wa0, wa1, cs_calc, fa, fb;
  logic [4:0] nval_q, nval_d, cnt_q, cnt_d, tgt_q, tgt_d;
  logic [15:0] addr_q, addr_d, wdata_q, wdata_d, wd0, wd1, base_v, dec_res;
  logic [31:0] opnd_q, opnd_d, res;
  logic pi_q, pi_d, ill_q, ill_d, we0, we1, carry, use_dbl;
  logic [7:0] opc;
  // index register zero means no indexing
  function automatic logic [15:0] idx_val(input logic [3:0] sel, input logic [15:0] v);
    idx_val = (sel == 4'h0) ? 16'h0000 : v;
  endfunction : idx_val
  // status code from sign, zero and carry of the current result
  ilad_cs_gen u_cs (.i_res(res), .i_dbl(use_dbl), .i_carry(carry), .o_cs(cs_calc));

  assign opc = i_instr[15:8];
  assign fa = i_instr[7:4];
  assign fb = i_instr[3:0];
  assign base_v = rf_q[BASE_REG_OFS + {2'b00, i_instr[9:8]}];
  assign dec_res = opnd_q[15:0] - {11'h000, nval_q};

  // sequencing, decode and datapath next state
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    ra_d = ra_q;
    rb_d = rb_q;
    nval_d = nval_q;
    tgt_d = tgt_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    opnd_d = opnd_q;
    cs_d = cs_q;
    pi_d = 1'b0;
    ill_d = 1'b0;
    cnt_d = (st_q == S_IDLE) ? 5'd0 : cnt_q + 5'd1;
    we0 = 1'b0;
    we1 = 1'b0;
    wa0 = ra_q;
    wa1 = ra_q + 4'h1;
    wd0 = 16'h0000;
    wd1 = 16'h0000;
    res = 32'h0000_0000;
    carry = 1'b0;
    use_dbl = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (i_start) begin
          cnt_d = 5'd1;
          ra_d = fa;
          rb_d = fb;
          st_d = S_EXEC;
          op_d = ILAD_OP_CONJ;
          opnd_d = {16'h0000, rf_q[fb]};
          if (opc == OPC_MEM_DEC) begin
            op_d = ILAD_OP_DEC; // [RQ5]
            nval_d = {1'b0, fa} + 5'd1;
            addr_d = i_ext + idx_val(fb, rf_q[fb]);
            tgt_d = CYC_MEM_DEC; // [RQ6]
            st_d = S_RD;
          end else if (opc == OPC_DBL_MAG) begin
            op_d = ILAD_OP_DMAG;
            opnd_d = {rf_q[fb], rf_q[fb + 4'h1]};
            tgt_d = rf_q[fb][15] ? CYC_DBL_NEG : CYC_DBL_POS; // [RQ10]
          end else if (opc == OPC_SGL_MAG) begin
            op_d = ILAD_OP_SMAG;
            tgt_d = rf_q[fb][15] ? CYC_SGL_NEG : CYC_SGL_POS; // [RQ14]
          end else if (opc == OPC_CONJ_MEM || opc == OPC_NCONJ_MEM) begin
            op_d = (opc == OPC_CONJ_MEM) ? ILAD_OP_CONJ : ILAD_OP_NCONJ;
            addr_d = i_ext + idx_val(fb, rf_q[fb]);
            tgt_d = (opc == OPC_CONJ_MEM) ? CYC_CONJ_MEM : CYC_NCONJ_MEM; // [RQ17] [RQ24]
            st_d = S_RD;
          end else if (opc == OPC_CONJ_RR || opc == OPC_NCONJ_RR) begin
            op_d = (opc == OPC_CONJ_RR) ? ILAD_OP_CONJ : ILAD_OP_NCONJ;
            tgt_d = (opc == OPC_CONJ_RR) ? CYC_CONJ_RR : CYC_NCONJ_RR; // [RQ21]
          end else if (opc == OPC_IMM_GRP && (fb == SUB_CONJ_IMM || fb == SUB_NCONJ_IMM)) begin
            op_d = (fb == SUB_CONJ_IMM) ? ILAD_OP_CONJ : ILAD_OP_NCONJ;
            opnd_d = {16'h0000, i_ext};
            tgt_d = (fb == SUB_CONJ_IMM) ? CYC_CONJ_IMM : CYC_NCONJ_IMM; // [RQ20]
          end else if (i_instr[15:12] == NIB_BASE_REL && i_instr[11:10] == SC_CONJ_BREL) begin
            ra_d = 4'h2;
            addr_d = base_v + {8'h00, i_instr[7:0]}; // [RQ18]
            tgt_d = CYC_CONJ_BASE;
            st_d = S_RD;
          end else if (i_instr[15:12] == NIB_BASE_IDX && i_instr[11:10] == SC_CONJ_BIDX
                       && fa == SUB_CONJ_BIDX) begin
            ra_d = 4'h2;
            addr_d = base_v + idx_val(fb, rf_q[fb]); // [RQ19]
            tgt_d = CYC_CONJ_BASE;
            st_d = S_RD;
          end else begin
            op_d = ILAD_OP_ILL;
            tgt_d = CYC_ILLEGAL;
            ill_d = 1'b1;
            st_d = S_DONE;
          end
        end
      end
      S_RD: begin
        if (i_mem_ack) begin
          opnd_d = {16'h0000, i_mem_rdata};
          st_d = S_EXEC; // [RQ25]
        end
      end
      S_EXEC: begin
        st_d = S_PAD;
        case (op_q)
          ILAD_OP_DEC: begin
            res = {16'h0000, dec_res}; // [RQ1]
            carry = opnd_q[15:0] >= {11'h000, nval_q};
            cs_d = cs_calc; // [RQ4]
            pi_d = opnd_q[15] & ~dec_res[15]; // [RQ2]
            wdata_d = dec_res;
            st_d = S_WR; // [RQ3] [RQ25]
          end
          ILAD_OP_DMAG: begin
            use_dbl = 1'b1;
            res = opnd_q[31] ? (32'h0000_0000 - opnd_q) : opnd_q;
            cs_d = cs_calc; // [RQ9]
            if (opnd_q == DBL_MIN) begin
              pi_d = 1'b1; // [RQ8]
            end else begin
              we0 = 1'b1;
              wd0 = res[31:16]; // [RQ7]
              we1 = 1'b1;
              wd1 = res[15:0];
            end
          end
          ILAD_OP_SMAG: begin
            res = {16'h0000, opnd_q[15] ? (16'h0000 - opnd_q[15:0]) : opnd_q[15:0]};
            cs_d = cs_calc; // [RQ13]
            if (opnd_q[15:0] == SGL_MIN) begin
              pi_d = 1'b1; // [RQ12]
            end else begin
              we0 = 1'b1;
              wd0 = res[15:0]; // [RQ11]
            end
          end
          ILAD_OP_CONJ, ILAD_OP_NCONJ: begin
            res[15:0] = rf_q[ra_q] & opnd_q[15:0]; // [RQ15]
            if (op_q == ILAD_OP_NCONJ) begin
              res[15:0] = ~res[15:0]; // [RQ22] [RQ23]
            end
            cs_d = cs_calc; // [RQ16]
            we0 = 1'b1;
            wd0 = res[15:0];
          end
          default: begin
            st_d = S_DONE;
          end
        endcase
      end
      S_WR: begin
        if (i_mem_ack) begin
          st_d = S_PAD;
        end
      end
      S_PAD: begin
        // slow memory may already have used up the budget
        if (cnt_q >= tgt_q - 5'd2) begin
          st_d = S_DONE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= S_IDLE;
      op_q <= ILAD_OP_ILL;
      ra_q <= 4'h0;
      rb_q <= 4'h0;
      nval_q <= 5'd0;
      cnt_q <= 5'd0;
      tgt_q <= 5'd0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      opnd_q <= 32'h0000_0000;
      cs_q <= 4'h0;
      pi_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      ra_q <= ra_d;
      rb_q <= rb_d;
      nval_q <= nval_d;
      cnt_q <= cnt_d;
      tgt_q <= tgt_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      opnd_q <= opnd_d;
      cs_q <= cs_d;
      pi_q <= pi_d;
      ill_q <= ill_d;
    end
  end

  // register file; execution writes win over a load to the same word
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rf_q <= '{default: 16'h0000};
    end else begin
      if (i_ld_en) begin
        rf_q[i_ld_sel] <= i_ld_data;
      end
      if (we0) begin
        rf_q[wa0] <= wd0;
      end
      if (we1) begin
        rf_q[wa1] <= wd1;
      end
    end
  end

  // outputs
  assign o_busy = (st_q != S_IDLE);
  assign o_done = (st_q == S_DONE);
  assign o_illegal = ill_q;
  assign o_rd_data = rf_q[i_rd_sel];
  assign o_mem_req = (st_q == S_RD) || (st_q == S_WR);
  assign o_mem_we = (st_q == S_WR);
  assign o_mem_addr = addr_q;
  assign o_mem_wdata = wdata_q;
  assign o_cs = cs_q;
  assign o_pending_interrupt_set = {{(15 - PI_FIX_OVF_BIT){1'b0}}, pi_q, {PI_FIX_OVF_BIT{1'b0}}};

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  chk_dec_wdata: assert property (o_mem_we // [RQ1]
    |-> o_mem_wdata + {11'h000, nval_q} == opnd_q[15:0])
    else $error("decrement store value wrong");
  chk_dec_ovf: assert property (st_q == S_EXEC && op_q == ILAD_OP_DEC && opnd_q[15] // [RQ2]
    && !dec_res[15] |=> o_pending_interrupt_set[PI_FIX_OVF_BIT])
    else $error("decrement overflow not flagged");
  chk_dec_store_ovf: assert property (pi_q && op_q == ILAD_OP_DEC |-> o_mem_we) // [RQ3]
    else $error("overflowed decrement skipped store");
  chk_dec_carry: assert property (o_mem_we // [RQ4]
    |-> o_cs[3] == (opnd_q[15:0] >= {11'h000, nval_q}))
    else $error("decrement carry status wrong");
  chk_rd_wr_seq: assert property (st_q == S_RD && op_q == ILAD_OP_DEC && i_mem_ack // [RQ25]
    |=> (st_q == S_EXEC && !o_mem_req) ##1 (o_mem_we && o_mem_addr == $past(o_mem_addr, 2)))
    else $error("decrement access order broken");
  chk_cycle_budget: assert property ($rose(o_done) && op_q != ILAD_OP_ILL // [RQ6]
    |-> cnt_q >= tgt_q - 5'd1)
    else $error("instruction ended early");
  chk_smag_ovf: assert property (st_q == S_EXEC && op_q == ILAD_OP_SMAG // [RQ12]
    && opnd_q[15:0] == SGL_MIN |=> pi_q && o_cs == CS_NEG)
    else $error("single magnitude overflow missed");
  chk_dmag_ovf: assert property (st_q == S_EXEC && op_q == ILAD_OP_DMAG // [RQ8]
    && opnd_q == DBL_MIN |=> pi_q && o_cs == CS_NEG)
    else $error("double magnitude overflow missed");
  chk_dmag_result: assert property (st_q == S_EXEC && op_q == ILAD_OP_DMAG && opnd_q[31] // [RQ7]
    && opnd_q != DBL_MIN && !i_ld_en |=> {rf_q[ra_q], rf_q[ra_q + 4'h1]}
    == 32'h0000_0000 - $past(opnd_q))
    else $error("double magnitude result wrong");
  chk_not_form: assert property (st_q == S_EXEC && op_q == ILAD_OP_NCONJ && ra_q == rb_q // [RQ23]
    && tgt_q == CYC_NCONJ_RR && !i_ld_en |=> rf_q[ra_q] == ~$past(opnd_q[15:0]))
    else $error("register inverse wrong");
  chk_conj_cs: assert property (st_q == S_EXEC && op_q == ILAD_OP_CONJ // [RQ16]
    && (rf_q[ra_q] & opnd_q[15:0]) == 16'h0000 |=> o_cs == CS_ZERO)
    else $error("conjunction zero status wrong");

  cov_dec_done: cover property (op_q == ILAD_OP_DEC && o_done);
  cov_dmag_neg: cover property (st_q == S_EXEC && op_q == ILAD_OP_DMAG && opnd_q[31]);
  cov_not_form: cover property (st_q == S_EXEC && op_q == ILAD_OP_NCONJ && ra_q == rb_q);
endmodule : ilad_unit

/* File: tb_top.sv */
// Purpose: self-checking bench for the logic/magnitude/decrement unit
// Assumes: registers reloaded from a fixed image before every row
// Notes: cycle counts assume prompt acks except in the slow memory test
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [15:0] ins, ext; logic [7:0] ma; logic [15:0] mv; logic [3:0] rg;
    logic [15:0] ex; logic [3:0] cs; int cy; logic pi;} ilad_row_t;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_start = 1'b0;
  logic i_ld_en = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [15:0] i_ext = 16'h0000;
  logic [15:0] i_ld_data = 16'h0000;
  logic [3:0] i_ld_sel = 4'h0;
  logic [3:0] i_rd_sel = 4'h0;
  logic [1:0] wt = 2'h0;
  logic o_busy, o_done, o_illegal, o_mem_req, o_mem_we, mem_ack;
  logic [15:0] o_rd_data, o_mem_addr, o_mem_wdata, mem_rdata, o_pis, v;
  logic [3:0] o_cs;
  logic pi, il;
  int errors = 0;
  int checked = 0;
  int cy, nr, nw;
  logic [15:0] img [16] = '{16'h0000, 16'hF0F0, 16'h3C3C, 16'h0002, 16'hFFFF, 16'hFFFE,
    16'h8000, 16'h0000, 16'h0007, 16'hFFFB, 16'h8F00, 16'hF0FF, 16'h0100, 16'h0060,
    16'h00FF, 16'h1234};
  // instr, second word, memory slot and word, register, result, status, cycles, overflow
  ilad_row_t rows [24] = '{
    '{16'hE312,16'h0000,8'h00,16'h0000,4'h1,16'h3030,4'h4,4,1'b0},
    '{16'hE3AB,16'h0000,8'h00,16'h0000,4'hA,16'h8000,4'h1,4,1'b0},
    '{16'hE36E,16'h0000,8'h00,16'h0000,4'h6,16'h0000,4'h2,4,1'b0},
    '{16'hE213,16'h0040,8'h42,16'h00FF,4'h1,16'h00F0,4'h4,12,1'b0},
    '{16'hE220,16'h0044,8'h44,16'h0FF0,4'h2,16'h0C30,4'h4,12,1'b0},
    '{16'h3405,16'h0000,8'h05,16'hF00F,4'h2,16'h300C,4'h4,11,1'b0},
    '{16'h41E3,16'h0000,8'h62,16'hFF00,4'h2,16'h3C00,4'h4,11,1'b0},
    '{16'h4A47,16'h8F0F,8'h00,16'h0000,4'h4,16'h8F0F,4'h1,11,1'b0},
    '{16'hE71E,16'h0000,8'h00,16'h0000,4'h1,16'hFF0F,4'h1,7,1'b0},
    '{16'hE777,16'h0000,8'h00,16'h0000,4'h7,16'hFFFF,4'h1,7,1'b0},
    '{16'hE640,16'h0046,8'h46,16'hFFFF,4'h4,16'h0000,4'h2,15,1'b0},
    '{16'h4AFB,16'hEDCB,8'h00,16'h0000,4'hF,16'hFFFF,4'h1,14,1'b0},
    '{16'hA419,16'h0000,8'h00,16'h0000,4'h1,16'h0005,4'h4,10,1'b0},
    '{16'hA488,16'h0000,8'h00,16'h0000,4'h8,16'h0007,4'h4,5,1'b0},
    '{16'hA477,16'h0000,8'h00,16'h0000,4'h7,16'h0000,4'h2,5,1'b0},
    '{16'hA416,16'h0000,8'h00,16'h0000,4'h1,16'hF0F0,4'h1,10,1'b1},
    '{16'hA5D4,16'h0000,8'h00,16'h0000,4'hE,16'h0002,4'h4,21,1'b0},
    '{16'hA5D4,16'h0000,8'h00,16'h0000,4'hD,16'h0000,4'h4,21,1'b0},
    '{16'hA5E8,16'h0000,8'h00,16'h0000,4'hF,16'hFFFB,4'h4,13,1'b0},
    '{16'hA536,16'h0000,8'h00,16'h0000,4'h3,16'h0002,4'h1,21,1'b1},
    '{16'hB310,16'h0048,8'h48,16'h0005,4'h0,16'h0003,4'hC,17,1'b0},
    '{16'hB3F3,16'h0040,8'h42,16'h8005,4'h0,16'h7FF5,4'hC,17,1'b1},
    '{16'hB300,16'h004A,8'h4A,16'h0000,4'h0,16'hFFFF,4'h1,17,1'b0},
    '{16'hB300,16'h004C,8'h4C,16'h0001,4'h0,16'h0000,4'hA,17,1'b0}};

  ilad_unit u_ilad_unit (.i_clk(i_clk), .i_srst(i_srst), .i_start(i_start),
    .i_instr(i_instr), .i_ext(i_ext), .o_busy(o_busy), .o_done(o_done),
    .o_illegal(o_illegal), .i_ld_en(i_ld_en), .i_ld_sel(i_ld_sel), .i_ld_data(i_ld_data),
    .i_rd_sel(i_rd_sel), .o_rd_data(o_rd_data), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rdata), .o_cs(o_cs), .o_pending_interrupt_set(o_pis));
  ilad_mem_model u_mem (.i_clk(i_clk), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_wait(wt), .o_ack(mem_ack),
    .o_rdata(mem_rdata));

  // 100 MHz clock
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp_val

  task cmp_cnt(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      errors++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : cmp_cnt

  // back-to-back loads keep the enable up, so it never toggles within a step
  task load_img;
    for (int r = 0; r < 16; r++) begin
      i_ld_en <= 1'b1;
      i_ld_sel <= r[3:0];
      i_ld_data <= img[r];
      @(posedge i_clk);
    end
    i_ld_en <= 1'b0;
  endtask : load_img

  task rd(input logic [3:0] r);
    i_rd_sel <= r;
    @(posedge i_clk);
    v = o_rd_data;
  endtask : rd

  // edges counted after the one that takes the start, up to the done cycle
  task run(input logic [15:0] ins, input logic [15:0] ext);
    nr = u_mem.n_rd;
    nw = u_mem.n_wr;
    cy = 0;
    pi = 1'b0;
    il = 1'b0;
    i_instr <= ins;
    i_ext <= ext;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    do begin
      @(posedge i_clk);
      cy++;
      pi = pi | (o_pis[4] === 1'b1);
      il = il | (o_illegal === 1'b1);
    end while (o_done !== 1'b1 && cy < 64);
    cmp_val({15'h0000, o_done}, 16'h0001, "done seen");
    nr = u_mem.n_rd - nr;
    nw = u_mem.n_wr - nw;
  endtask : run

  // a hang cuts the run short well past the expected 760 or so cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim;
  end

  // table rows first, then the awkward cases
  initial begin
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    foreach (rows[k]) begin
      load_img;
      u_mem.mem[rows[k].ma] = rows[k].mv;
      run(rows[k].ins, rows[k].ext);
      if (rows[k].ins[15:8] == 8'hB3) begin
        cmp_val(u_mem.mem[rows[k].ma], rows[k].ex, "stored word");
        cmp_val({u_mem.pair_ok, 7'h00, nr[3:0], nw[3:0]}, 16'h8011, "accesses");
      end else begin
        rd(rows[k].rg);
        cmp_val(v, rows[k].ex, "register");
      end
      cmp_val({12'h000, o_cs}, {12'h000, rows[k].cs}, "status");
      cmp_cnt(cy + 1, rows[k].cy, "cycles");
      cmp_val({15'h0000, pi}, {15'h0000, rows[k].pi}, "overflow");
      $display("row %0d done", k);
    end
    // unknown opcode gives a flag and ends early
    run(16'hFF00, 16'h0000);
    cmp_val({15'h0000, il}, 16'h0001, "illegal flag");
    cmp_cnt(cy + 1, 2, "illegal cycles");
    $display("illegal opcode test done");
    // a second start while busy must be dropped
    load_img;
    i_instr <= 16'hE312;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_instr <= 16'hE3AB;
    @(posedge i_clk);
    i_start <= 1'b0;
    for (int n = 0; n < 8 && o_done !== 1'b1; n++) @(posedge i_clk);
    cmp_val({15'h0000, o_done}, 16'h0001, "refused done");
    rd(4'hA);
    cmp_val(v, 16'h8F00, "refused start");
    $display("busy refusal test done");
    // slow memory still gives one read then one write of the same word
    wt <= 2'h3;
    load_img;
    u_mem.mem[8'h48] = 16'h0005;
    run(16'hB310, 16'h0048);
    cmp_val(u_mem.mem[8'h48], 16'h0003, "slow stored word");
    cmp_val({u_mem.pair_ok, 7'h00, nr[3:0], nw[3:0]}, 16'h8011, "slow accesses");
    cmp_val({12'h000, o_cs}, 16'h000C, "slow status");
    $display("slow memory test done");
    // reset in mid-operation clears everything
    i_instr <= 16'hB310;
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (5) @(posedge i_clk);
    cmp_val({12'h000, o_busy, o_mem_req, o_done, o_illegal}, 16'h0000, "reset flags");
    cmp_val({12'h000, o_cs} | o_pis, 16'h0000, "reset status");
    i_srst <= 1'b0;
    wt <= 2'h0;
    rd(4'h1);
    cmp_val(v, 16'h0000, "reset register");
    $display("reset test done");
    end_sim;
  end
endmodule : tb_top
